// [include/twm_pkg.sv]
// constants and types shared by the two-wire master block
package twm_pkg;
	localparam int AW = 8;
	localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_ADDR = 8'h0C;
	localparam logic [7:0] OFS_DATA = 8'h10;
	localparam logic [7:0] OFS_BAUD = 8'h14;
	// master_ctrl_one fields
	localparam int C1_ENABLE = 0;
	localparam int C1_SMART = 1;
	// master_ctrl_two fields
	localparam int C2_CMD_LO = 0;
	localparam int C2_ACKACT = 2;
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_RECV = 2'h2;
	localparam logic [1:0] CMD_STOP = 2'h3;
	// master_status_reg fields
	localparam int ST_LINE_LO = 0;
	localparam int ST_RXACK = 4;
	localparam int ST_BUSY = 5;
	localparam int ST_DONE = 6;
	localparam logic [1:0] LINE_UNKNOWN = 2'h0;
	localparam logic [1:0] LINE_IDLE = 2'h1;
	localparam logic [1:0] LINE_OWNER = 2'h2;
	localparam logic [1:0] LINE_BUSY = 2'h3;
	localparam logic [7:0] BAUD_RESET = 8'h13;
	localparam logic [1:0] ENABLE_SETTLE = 2'h2;
	typedef enum logic [3:0] {
		TWM_IDLE = 4'h0,
		TWM_RS_LO = 4'h1,
		TWM_ST_HI = 4'h2,
		TWM_ST_A = 4'h3,
		TWM_BIT_LO = 4'h4,
		TWM_BIT_HI = 4'h5,
		TWM_WAIT = 4'h6,
		TWM_SP_LO = 4'h7,
		TWM_SP_HI = 4'h8,
		TWM_SP_END = 4'h9,
		TWM_EX_LO = 4'hA,
		TWM_EX_HI = 4'hB
	} twm_state_t;
endpackage : twm_pkg

// [verilog/twm_master.sv]
// two-wire bus master with APB register access and bus monitor
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module twm_master (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [twm_pkg::AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	twm_pkg::twm_state_t state_q;
	logic [1:0] scl_sy_q, sda_sy_q;
	logic scl_s, sda_s, sda_prev_q;
	logic enable_q, smart_q, ackact_q, rxack_q, done_q, rx_q, misread_q;
	logic [1:0] line_q, en_age_q;
	logic [7:0] baud_q, cnt_q, addr_q, data_q, sh_q, rxdata_q;
	logic [3:0] bit_q;
	logic go_addr_q, go_data_q, go_recv_q, go_stop_q;
	logic scl_oe_q, sda_oe_q, pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic acc, wr, rd, tick, start_ev, stop_ev, mapped;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == twm_pkg::OFS_CTRL_ONE) || (a == twm_pkg::OFS_CTRL_TWO)
			|| (a == twm_pkg::OFS_STATUS) || (a == twm_pkg::OFS_ADDR)
			|| (a == twm_pkg::OFS_DATA) || (a == twm_pkg::OFS_BAUD);
	endfunction : is_mapped

	assign acc = psel_i && penable_i && pready_q;
	assign wr = acc && pwrite_i && mapped;
	assign rd = acc && !pwrite_i && mapped;
	assign mapped = is_mapped(paddr_i);
	assign scl_s = scl_sy_q[1];
	assign sda_s = sda_sy_q[1];
	assign tick = (cnt_q == baud_q);
	assign start_ev = sda_prev_q && !sda_s && scl_s;
	assign stop_ev = !sda_prev_q && sda_s && scl_s;

	// pins are open drain: only ever pulled low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = scl_oe_q;
	assign sda_oe_o = sda_oe_q;
	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			scl_sy_q <= 2'h3;
			sda_sy_q <= 2'h3;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			scl_sy_q <= {scl_sy_q[0], scl_i};
			sda_sy_q <= {sda_sy_q[0], sda_i};
			sda_prev_q <= sda_s;
		end
	end

	// apb slave: one wait-free access phase, error on unmapped offsets
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= psel_i && !penable_i && !pready_q;
			pslverr_q <= psel_i && !penable_i && !is_mapped(paddr_i);
			prdata_q <= 32'h0000_0000;
			if (psel_i && !penable_i && !pwrite_i)
			begin
				unique case (paddr_i)
					twm_pkg::OFS_CTRL_ONE:
						prdata_q[1:0] <= {smart_q, enable_q};
					twm_pkg::OFS_CTRL_TWO:
						prdata_q[twm_pkg::C2_ACKACT] <= ackact_q;
					twm_pkg::OFS_STATUS:
						prdata_q[6:0] <= {done_q, state_q != twm_pkg::TWM_IDLE,
							rxack_q, 2'h0, line_q};
					twm_pkg::OFS_ADDR: prdata_q[7:0] <= addr_q;
					twm_pkg::OFS_DATA: prdata_q[7:0] <= rxdata_q;
					twm_pkg::OFS_BAUD: prdata_q[7:0] <= baud_q;
					default: prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// control registers and one-cycle command pulses
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			enable_q <= 1'b0;
			smart_q <= 1'b0;
			ackact_q <= 1'b0;
			baud_q <= twm_pkg::BAUD_RESET;
			addr_q <= 8'h00;
			data_q <= 8'h00;
			go_addr_q <= 1'b0;
			go_data_q <= 1'b0;
			go_recv_q <= 1'b0;
			go_stop_q <= 1'b0;
		end
		else
		begin
			go_addr_q <= 1'b0;
			go_data_q <= 1'b0;
			go_recv_q <= rd && (paddr_i == twm_pkg::OFS_DATA) && smart_q
				&& rx_q && state_q == twm_pkg::TWM_WAIT;
			go_stop_q <= 1'b0;
			if (wr)
			begin
				unique case (paddr_i)
					twm_pkg::OFS_CTRL_ONE:
					begin
						// quick command bit has no storage
						enable_q <= pwdata_i[twm_pkg::C1_ENABLE];
						smart_q <= pwdata_i[twm_pkg::C1_SMART];
					end
					twm_pkg::OFS_CTRL_TWO:
					begin
						// timeout selection bits are dropped
						ackact_q <= pwdata_i[twm_pkg::C2_ACKACT];
						go_recv_q <= pwdata_i[1:0] == twm_pkg::CMD_RECV;
						go_stop_q <= pwdata_i[1:0] == twm_pkg::CMD_STOP;
					end
					twm_pkg::OFS_ADDR:
					begin
						addr_q <= pwdata_i[7:0];
						go_addr_q <= 1'b1;
					end
					twm_pkg::OFS_DATA:
					begin
						data_q <= pwdata_i[7:0];
						go_data_q <= 1'b1;
					end
					twm_pkg::OFS_BAUD: baud_q <= pwdata_i[7:0];
					default: baud_q <= baud_q;
				endcase
			end
		end
	end

	// cycles since enable, saturating; address write inside window is flawed
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			en_age_q <= 2'h0;
			misread_q <= 1'b0;
		end
		else
		begin
			if (!enable_q)
				en_age_q <= 2'h0;
			else if (en_age_q != twm_pkg::ENABLE_SETTLE)
				en_age_q <= en_age_q + 2'h1;
			if (!enable_q || (start_ev && misread_q))
				misread_q <= 1'b0;
			else if (wr && paddr_i == twm_pkg::OFS_ADDR
				&& en_age_q < twm_pkg::ENABLE_SETTLE)
				misread_q <= 1'b1;
		end
	end

	// bus monitor: line condition field; kept while disabled so that it
	// can be forced idle before enabling and an early address still starts
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			line_q <= twm_pkg::LINE_UNKNOWN;
		else if (enable_q && (stop_ev || (start_ev && misread_q)))
			line_q <= twm_pkg::LINE_IDLE;
		else if (enable_q && start_ev)
			line_q <= (state_q != twm_pkg::TWM_IDLE) ? twm_pkg::LINE_OWNER
				: twm_pkg::LINE_BUSY;
		else if (wr && paddr_i == twm_pkg::OFS_STATUS
			&& pwdata_i[1:0] == twm_pkg::LINE_IDLE)
			line_q <= twm_pkg::LINE_IDLE;
	end

	// done flag: set by byte end, cleared by writing one, set wins
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			done_q <= 1'b0;
		else if (state_q == twm_pkg::TWM_BIT_HI && tick && scl_s && bit_q == 4'h8)
			done_q <= 1'b1;
		else if (wr && paddr_i == twm_pkg::OFS_STATUS && pwdata_i[twm_pkg::ST_DONE])
			done_q <= 1'b0;
	end

	// bit engine and pin drivers
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= twm_pkg::TWM_IDLE;
			cnt_q <= 8'h00;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rx_q <= 1'b0;
			rxack_q <= 1'b0;
			rxdata_q <= 8'h00;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else if (!enable_q)
		begin
			state_q <= twm_pkg::TWM_IDLE;
			cnt_q <= 8'h00;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else
		begin
			// timer restarts from zero while a slave stretches scl
			cnt_q <= (tick || (!scl_s && !scl_oe_q)) ? 8'h00 : cnt_q + 8'h01;
			unique case (state_q)
				twm_pkg::TWM_IDLE, twm_pkg::TWM_WAIT:
				begin
					cnt_q <= 8'h00;
					if (go_addr_q && (line_q == twm_pkg::LINE_IDLE
						|| state_q == twm_pkg::TWM_WAIT))
					begin
						sh_q <= addr_q;
						rx_q <= 1'b0;
						state_q <= (state_q == twm_pkg::TWM_WAIT)
							? twm_pkg::TWM_RS_LO : twm_pkg::TWM_ST_HI;
					end
					else if (state_q == twm_pkg::TWM_WAIT && go_stop_q)
						state_q <= twm_pkg::TWM_SP_LO;
					else if (state_q == twm_pkg::TWM_WAIT
						&& ((go_data_q && !rx_q) || (go_recv_q && rx_q)))
					begin
						sh_q <= data_q;
						bit_q <= 4'h0;
						state_q <= twm_pkg::TWM_BIT_LO;
					end
				end
				twm_pkg::TWM_RS_LO:
				begin
					scl_oe_q <= 1'b1;
					sda_oe_q <= 1'b0;
					if (tick)
						state_q <= twm_pkg::TWM_ST_HI;
				end
				twm_pkg::TWM_ST_HI:
				begin
					scl_oe_q <= 1'b0;
					if (tick)
						state_q <= twm_pkg::TWM_ST_A;
				end
				twm_pkg::TWM_ST_A:
				begin
					sda_oe_q <= 1'b1;
					bit_q <= 4'h0;
					if (tick)
						state_q <= twm_pkg::TWM_BIT_LO;
				end
				twm_pkg::TWM_BIT_LO:
				begin
					scl_oe_q <= 1'b1;
					// data moves one cycle after scl falls: keeps hold time
					if (scl_oe_q && bit_q < 4'h8)
						sda_oe_q <= !rx_q && !sh_q[7];
					else if (scl_oe_q)
						sda_oe_q <= rx_q && !ackact_q;
					if (tick)
						state_q <= twm_pkg::TWM_BIT_HI;
				end
				twm_pkg::TWM_BIT_HI:
				begin
					scl_oe_q <= 1'b0;
					if (tick)
					begin
						bit_q <= bit_q + 4'h1;
						state_q <= twm_pkg::TWM_BIT_LO;
						if (bit_q < 4'h8)
							sh_q <= {sh_q[6:0], sda_s};
						else
						begin
							scl_oe_q <= 1'b1;
							state_q <= twm_pkg::TWM_WAIT;
							if (rx_q)
								rxdata_q <= sh_q;
							else
								rxack_q <= sda_s;
							if (rx_q && ackact_q && smart_q)
								state_q <= twm_pkg::TWM_EX_LO;
							else if (!rx_q && !sda_s && sh_q == addr_q
								&& addr_q[0])
							begin
								// read address acknowledged: fetch first byte
								rx_q <= 1'b1;
								bit_q <= 4'h0;
								state_q <= twm_pkg::TWM_BIT_LO;
							end
						end
					end
				end
				twm_pkg::TWM_EX_LO:
				begin
					scl_oe_q <= 1'b1;
					sda_oe_q <= 1'b0;
					if (tick)
						state_q <= twm_pkg::TWM_EX_HI;
				end
				twm_pkg::TWM_EX_HI:
				begin
					scl_oe_q <= 1'b0;
					if (tick)
					begin
						scl_oe_q <= 1'b1;
						state_q <= twm_pkg::TWM_WAIT;
					end
				end
				twm_pkg::TWM_SP_LO:
				begin
					scl_oe_q <= 1'b1;
					sda_oe_q <= 1'b1;
					if (tick)
						state_q <= twm_pkg::TWM_SP_HI;
				end
				twm_pkg::TWM_SP_HI:
				begin
					scl_oe_q <= 1'b0;
					if (tick)
						state_q <= twm_pkg::TWM_SP_END;
				end
				twm_pkg::TWM_SP_END:
				begin
					sda_oe_q <= 1'b0;
					if (tick)
						state_q <= twm_pkg::TWM_IDLE;
				end
				default: state_q <= twm_pkg::TWM_IDLE;
			endcase
		end
	end
endmodule : twm_master
`default_nettype wire

// [dv/twm_master_asserts.sv]
// port checker for the two-wire master
`timescale 1ns/1ps
`default_nettype none
module twm_master_asserts (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [twm_pkg::AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic acc;
	assign acc = psel_i & penable_i & pready_o;
	a_setup_answer: assert property (psel_i & !penable_i |=> pready_o)
		else $error("no answer after setup");
	a_high_unmapped: assert property (psel_i & penable_i
		& paddr_i > twm_pkg::OFS_BAUD |-> pslverr_o)
		else $error("no error for unmapped offset");
	a_timeout_hidden: assert property (acc & !pwrite_i
		& paddr_i == twm_pkg::OFS_CTRL_TWO |-> prdata_o[31:3] == 29'h0)
		else $error("timeout bits visible");
	a_quick_hidden: assert property (acc & !pwrite_i
		& paddr_i == twm_pkg::OFS_CTRL_ONE |-> prdata_o[31:2] == 30'h0)
		else $error("quick command bit visible");
	a_idle_forced: assert property (acc & pwrite_i
		& paddr_i == twm_pkg::OFS_STATUS & pwdata_i[1:0] == 2'h1
		##3 acc & !pwrite_i & paddr_i == twm_pkg::OFS_STATUS
		|-> prdata_o[1:0] == twm_pkg::LINE_IDLE)
		else $error("line not idle after forcing");
endmodule : twm_master_asserts
bind twm_master twm_master_asserts u_chk (.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
`default_nettype wire

// [dv/twm_slave_model.sv]
// bus slave model: acks, returns a fixed byte on reads
`timescale 1ns/1ps
`default_nettype none
module twm_slave_model #(parameter logic [7:0] RD_BYTE = 8'h5A) (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_oe_o
);
	logic [3:0] bit_q = 4'h9;
	logic [7:0] sh_q = 8'h00;
	logic adr_q = 1'b0;
	logic rd_q = 1'b0;
	initial sda_oe_o = 1'b0;
	always @(negedge sda_i)
		if (scl_i)
		begin
			bit_q = 4'hF;
			adr_q = 1'b1;
		end
	// master nack ends the read
	always @(posedge scl_i)
		if (bit_q < 4'h8)
			sh_q = {sh_q[6:0], sda_i};
		else if (sda_i)
			rd_q = 1'b0;
	always @(negedge scl_i)
	begin
		// direction is known only once the address acknowledge is over
		if (bit_q == 4'h8 && adr_q)
		begin
			rd_q = sh_q[0];
			adr_q = 1'b0;
		end
		bit_q = (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
		sda_oe_o = (bit_q == 4'h8) ? adr_q | !rd_q
			: rd_q & (bit_q < 4'h8) & !RD_BYTE[3'h7 - bit_q[2:0]];
	end
endmodule : twm_slave_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the two-wire master
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;
		logic e;} twm_row_t;
	twm_row_t rows [4] = '{'{8'h00, 32'hFFFFFFFF, 32'h3, 1'b0},
		'{8'h04, 32'hFFFFFFF8, 32'h0, 1'b0},
		'{8'h14, 32'h3, 32'h3, 1'b0}, '{8'h18, 32'h5, 32'h0, 1'b1}};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, scl_oe, sda_oe, slv_oe;
	wire logic scl;
	wire logic sda;
	int err_count = 0;
	int tests_run = 0;
	int rises = 0;
	assign scl = !scl_oe;
	assign sda = !(sda_oe | slv_oe);
	always #20 clk = !clk;
	always @(posedge scl) rises++;
	twm_master u_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe_o(sda_oe));
	twm_slave_model u_slv (.scl_i(scl), .sda_i(sda), .sda_oe_o(slv_oe));
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] x);
		tests_run++;
		if (s !== x)
		begin
			err_count++;
			$display("unexpected %s: exp %h seen %h", n, x, s);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input bit chain = 1'b0);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		pen <= 1'b0;
		// a chained call sets up the next transfer in this same cycle
		if (!chain)
		begin
			psel <= 1'b0;
			@(posedge clk);
		end
	endtask : apb
	task complete_run;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check("scl drive", scl_oe, 32'h0);
		check("ready idle", pready, 32'h0);
		check("error idle", pslverr, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		check("baud", rd, 32'h13);
		$display("reset test done");
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].w);
			apb(1'b0, rows[i].a, 32'h0);
			check("readback", rd, rows[i].r);
			check("slverr", er, rows[i].e);
		end
		$display("table test done");
		apb(1'b0, 8'h08, 32'h0);
		check("line unknown", rd[1:0], 32'h0);
		apb(1'b1, 8'h08, 32'h1);
		apb(1'b0, 8'h08, 32'h0);
		check("line idle", rd[1:0], 32'h1);
		apb(1'b1, 8'h0C, 32'hA0);
		do apb(1'b0, 8'h08, 32'h0); while (rd[6] !== 1'b1);
		check("line owner", rd[1:0], 32'h2);
		check("rx ack", rd[4], 32'h0);
		apb(1'b1, 8'h04, 32'h3);
		repeat (40) @(posedge clk);
		$display("write test done");
		for (int s = 0; s < 2; s++)
		begin
			apb(1'b1, 8'h00, 32'h1 | (s << 1));
			apb(1'b1, 8'h08, 32'h1);
			apb(1'b1, 8'h04, 32'h4);
			rises = 0;
			apb(1'b1, 8'h0C, 32'hA1);
			repeat (300) @(posedge clk);
			check("scl pulses", rises, 32'h12 + s);
			apb(1'b1, 8'h04, 32'h7);
			repeat (100) @(posedge clk);
			apb(1'b0, 8'h10, 32'h0);
			check("rx byte", rd, 32'h5A);
		end
		$display("pulse test done");
		apb(1'b1, 8'h08, 32'h40);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		check("done cleared", rd[6], 32'h0);
		apb(1'b1, 8'h00, 32'h1, 1'b1);
		apb(1'b1, 8'h0C, 32'hA0);
		do apb(1'b0, 8'h08, 32'h0); while (rd[6] !== 1'b1);
		check("line misread", rd[1:0], 32'h1);
		apb(1'b1, 8'h04, 32'h3);
		repeat (40) @(posedge clk);
		$display("misread test done");
		complete_run;
	end
	initial
	begin
		#200000;
		err_count++;
		complete_run;
	end
endmodule : testbench
`default_nettype wire
